// ==== rtl/bit_fanout.v ====
// spreads a register's control bits to per-unit reset outputs
module bit_fanout #(
	parameter WIDTH = 8
) (
	input wire [31:0] regValue, // register contents
	input wire [WIDTH*6-1:0] bitSel, // six-bit field per output, low five bits index regValue
	output wire [WIDTH-1:0] rstOut // held-reset level per unit
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_out
			assign rstOut[i] = regValue[bitSel[i*6 +: 5]];
		end
	endgenerate
endmodule

// ==== rtl/periph_soft_reset_regs.v ====
// peripheral software reset control registers for timers, serial units and pin ports
//
// Decided for this implementation: the strobed register port.
`include "periph_soft_reset_regs.vh"

module periph_soft_reset_regs (
	input wire clk, // system clock, 25 MHz
	input wire reset, // synchronous reset, active high
	input wire [11:0] addr, // register byte address
	input wire [31:0] wrData, // write data
	input wire wrStrobe, // write strobe, one cycle
	input wire rdStrobe, // read strobe, one cycle
	output reg [31:0] rdData, // read data, the cycle after rdStrobe
	input wire [31:0] capability_mask_two, // present-unit bits for first register
	input wire [31:0] capability_mask_four, // present-port bits for second register
	output wire gp_tmr_unit0_rst, // timer unit 0 held in reset
	output wire gp_tmr_unit1_rst, // timer unit 1 held in reset
	output wire gp_tmr_unit2_rst, // timer unit 2 held in reset
	output wire gp_tmr_unit3_rst, // timer unit 3 held in reset
	output wire two_wire_unit0_rst, // two-wire unit 0 held in reset
	output wire two_wire_unit1_rst, // two-wire unit 1 held in reset
	output wire sync_serial_unit0_rst, // sync serial unit 0 held in reset
	output wire sync_serial_unit1_rst, // sync serial unit 1 held in reset
	output wire async_serial_unit0_rst, // async serial unit 0 held in reset
	output wire async_serial_unit1_rst, // async serial unit 1 held in reset
	output wire async_serial_unit2_rst, // async serial unit 2 held in reset
	output wire pin_port_a_rst, // port A held in reset
	output wire pin_port_b_rst, // port B held in reset
	output wire pin_port_c_rst, // port C held in reset
	output wire pin_port_d_rst, // port D held in reset
	output wire pin_port_e_rst, // port E held in reset
	output wire pin_port_f_rst, // port F held in reset
	output wire pin_port_g_rst, // port G held in reset
	output wire pin_port_h_rst // port H held in reset
);
	// ------------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------------
	function hit;
		input [11:0] a;
		input [11:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	wire [31:0] serialTimer_q;
	wire [31:0] pinPorts_q;
	wire [10:0] serialTimerRst;
	wire [7:0] pinPortRst;

	// ------------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------------
	soft_reset_field #(
		.IMPL_MASK(`SERIAL_TIMER_IMPL),
		.RESET_VALUE(`SERIAL_TIMER_RESET)
	) u_serialTimer (
		.clk(clk),
		.reset(reset),
		.wrEn(wrStrobe & hit(addr, `SERIAL_TIMER_OFFSET)),
		.wrData(wrData),
		.capMask(capability_mask_two),
		.value_q(serialTimer_q)
	);

	soft_reset_field #(
		.IMPL_MASK(`PIN_PORTS_IMPL),
		.RESET_VALUE(`PIN_PORTS_RESET)
	) u_pinPorts (
		.clk(clk),
		.reset(reset),
		.wrEn(wrStrobe & hit(addr, `PIN_PORTS_OFFSET)),
		.wrData(wrData),
		.capMask(capability_mask_four),
		.value_q(pinPorts_q)
	);

	// ------------------------------------------------------------------------
	// read port
	// ------------------------------------------------------------------------
	// unmapped addresses and reserved bits read zero
	always @(posedge clk) begin
		if (reset) begin
			rdData <= 32'h00000000;
		end else if (rdStrobe && hit(addr, `SERIAL_TIMER_OFFSET)) begin
			rdData <= serialTimer_q;
		end else if (rdStrobe && hit(addr, `PIN_PORTS_OFFSET)) begin
			rdData <= pinPorts_q;
		end else begin
			rdData <= 32'h00000000;
		end
	end

	// ------------------------------------------------------------------------
	// per-unit reset levels
	// ------------------------------------------------------------------------
	// level outputs: the unit stays in reset until software clears the bit
	bit_fanout #(
		.WIDTH(11)
	) u_serialFan (
		.regValue(serialTimer_q),
		.bitSel({6'd`GP_TMR_UNIT3_BIT, 6'd`GP_TMR_UNIT2_BIT, 6'd`GP_TMR_UNIT1_BIT,
			6'd`GP_TMR_UNIT0_BIT, 6'd`TWO_WIRE_UNIT1_BIT, 6'd`TWO_WIRE_UNIT0_BIT,
			6'd`SYNC_SERIAL_UNIT1_BIT, 6'd`SYNC_SERIAL_UNIT0_BIT,
			6'd`ASYNC_SERIAL_UNIT2_BIT, 6'd`ASYNC_SERIAL_UNIT1_BIT,
			6'd`ASYNC_SERIAL_UNIT0_BIT}),
		.rstOut(serialTimerRst)
	);

	bit_fanout #(
		.WIDTH(`PIN_PORT_COUNT)
	) u_portFan (
		.regValue(pinPorts_q),
		.bitSel({6'd7, 6'd6, 6'd5, 6'd4, 6'd3, 6'd2, 6'd1, 6'd0}),
		.rstOut(pinPortRst)
	);

	assign gp_tmr_unit3_rst = serialTimerRst[10];
	assign gp_tmr_unit2_rst = serialTimerRst[9];
	assign gp_tmr_unit1_rst = serialTimerRst[8];
	assign gp_tmr_unit0_rst = serialTimerRst[7];
	assign two_wire_unit1_rst = serialTimerRst[6];
	assign two_wire_unit0_rst = serialTimerRst[5];
	assign sync_serial_unit1_rst = serialTimerRst[4];
	assign sync_serial_unit0_rst = serialTimerRst[3];
	assign async_serial_unit2_rst = serialTimerRst[2];
	assign async_serial_unit1_rst = serialTimerRst[1];
	assign async_serial_unit0_rst = serialTimerRst[0];

	assign pin_port_h_rst = pinPortRst[7];
	assign pin_port_g_rst = pinPortRst[6];
	assign pin_port_f_rst = pinPortRst[5];
	assign pin_port_e_rst = pinPortRst[4];
	assign pin_port_d_rst = pinPortRst[3];
	assign pin_port_c_rst = pinPortRst[2];
	assign pin_port_b_rst = pinPortRst[1];
	assign pin_port_a_rst = pinPortRst[`PIN_PORT_A_BIT];
endmodule

// ==== rtl/periph_soft_reset_regs.vh ====
// offsets, field positions and reset values of the peripheral soft reset registers
`ifndef PERIPH_SOFT_RESET_REGS_VH
`define PERIPH_SOFT_RESET_REGS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define SERIAL_TIMER_OFFSET 12'h044
`define PIN_PORTS_OFFSET 12'h048
`define ADDR_WIDTH 12

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SERIAL_TIMER_RESET 32'h00000000
`define PIN_PORTS_RESET 32'h00000000

// ----------------------------------------------------------------------------
// field positions, first register
// ----------------------------------------------------------------------------
`define GP_TMR_UNIT0_BIT 16
`define GP_TMR_UNIT1_BIT 17
`define GP_TMR_UNIT2_BIT 18
`define GP_TMR_UNIT3_BIT 19
`define TWO_WIRE_UNIT0_BIT 12
`define TWO_WIRE_UNIT1_BIT 14
`define SYNC_SERIAL_UNIT0_BIT 4
`define SYNC_SERIAL_UNIT1_BIT 5
`define ASYNC_SERIAL_UNIT0_BIT 0
`define ASYNC_SERIAL_UNIT1_BIT 1
`define ASYNC_SERIAL_UNIT2_BIT 2

// implemented bits of the first register: 19:16, 14, 12, 5:4, 2:0
`define SERIAL_TIMER_IMPL 32'h000F5037

// ----------------------------------------------------------------------------
// field positions, second register
// ----------------------------------------------------------------------------
`define PIN_PORT_A_BIT 0
`define PIN_PORT_COUNT 8
`define PIN_PORTS_IMPL 32'h000000FF

`endif

// ==== rtl/soft_reset_field.v ====
// one software reset control register with capability-masked writes
module soft_reset_field #(
	parameter [31:0] IMPL_MASK = 32'h00000000,
	parameter [31:0] RESET_VALUE = 32'h00000000
) (
	input wire clk, // system clock
	input wire reset, // synchronous reset, active high
	input wire wrEn, // write strobe decoded for this register
	input wire [31:0] wrData, // write data
	input wire [31:0] capMask, // capability mask, 1 = unit present
	output reg [31:0] value_q // stored value
);
	wire [31:0] writable;
	wire [31:0] value_d;

	// only present, implemented bits take new data
	assign writable = IMPL_MASK & capMask;
	assign value_d = (value_q & ~writable) | (wrData & writable);

	always @(posedge clk) begin
		if (reset) begin
			value_q <= RESET_VALUE;
		end else if (wrEn) begin
			value_q <= value_d;
		end
	end
endmodule

// ==== verification/periph_soft_reset_regs_properties.sv ====
// port assertions for the peripheral soft reset registers
`include "periph_soft_reset_regs.vh"
module periph_soft_reset_regs_chk (
	input wire clk, // system clock
	input wire reset, // synchronous reset, active high
	input wire wrStrobe, // write strobe
	input wire rdStrobe, // read strobe
	input wire [11:0] addr, // byte address
	input wire [31:0] wrData, // write data
	input wire [31:0] rdData, // read data
	input wire [31:0] capability_mask_two, // present units, first register
	input wire [31:0] capability_mask_four, // present ports, second register
	input wire gp_tmr_unit0_rst, // timer 0 reset level
	input wire gp_tmr_unit1_rst, // timer 1 reset level
	input wire gp_tmr_unit2_rst, // timer 2 reset level
	input wire gp_tmr_unit3_rst, // timer 3 reset level
	input wire two_wire_unit0_rst, // two-wire 0 reset level
	input wire two_wire_unit1_rst, // two-wire 1 reset level
	input wire sync_serial_unit0_rst, // sync serial 0 reset level
	input wire sync_serial_unit1_rst, // sync serial 1 reset level
	input wire async_serial_unit0_rst, // async serial 0 reset level
	input wire async_serial_unit1_rst, // async serial 1 reset level
	input wire async_serial_unit2_rst, // async serial 2 reset level
	input wire pin_port_a_rst, // port A reset level
	input wire pin_port_b_rst, // port B reset level
	input wire pin_port_c_rst, // port C reset level
	input wire pin_port_d_rst, // port D reset level
	input wire pin_port_e_rst, // port E reset level
	input wire pin_port_f_rst, // port F reset level
	input wire pin_port_g_rst, // port G reset level
	input wire pin_port_h_rst // port H reset level
);
	timeunit 1ns;
	timeprecision 1ps;
	wire [19:0] one = {gp_tmr_unit3_rst, gp_tmr_unit2_rst, gp_tmr_unit1_rst, gp_tmr_unit0_rst, 1'h0,
		two_wire_unit1_rst, 1'h0, two_wire_unit0_rst, 6'h00, sync_serial_unit1_rst,
		sync_serial_unit0_rst, 1'h0, async_serial_unit2_rst, async_serial_unit1_rst,
		async_serial_unit0_rst};
	wire [7:0] two = {pin_port_h_rst, pin_port_g_rst, pin_port_f_rst, pin_port_e_rst,
		pin_port_d_rst, pin_port_c_rst, pin_port_b_rst, pin_port_a_rst};
	wire wrOne = wrStrobe && addr == `SERIAL_TIMER_OFFSET;
	wire wrTwo = wrStrobe && addr == `PIN_PORTS_OFFSET;
	wire rdOne = rdStrobe && addr == `SERIAL_TIMER_OFFSET;
	wire rdTwo = rdStrobe && addr == `PIN_PORTS_OFFSET;
	// absent units keep their old state, reserved bits stay zero
	wire [19:0] nextOne = (wrData[19:0] & capability_mask_two[19:0] |
		one & ~capability_mask_two[19:0]) & 20'hF5037;
	wire [7:0] nextTwo = wrData[7:0] & capability_mask_four[7:0] | two & ~capability_mask_four[7:0];
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wr_mask_one_a: assert property (wrOne |=> one == $past(nextOne))
		else $error("first register write wrong");
	wr_mask_two_a: assert property (wrTwo |=> two == $past(nextTwo))
		else $error("second register write wrong");
	hold_one_a: assert property (!wrOne |=> $stable(one))
		else $error("first register moved unwritten");
	hold_two_a: assert property (!wrTwo |=> $stable(two))
		else $error("second register moved unwritten");
	rd_one_a: assert property (rdOne |=> rdData == {12'h000, $past(one)})
		else $error("first register read wrong");
	rd_two_a: assert property (rdTwo |=> rdData == {24'h000000, $past(two)})
		else $error("second register read wrong");
	rd_zero_a: assert property (!rdOne && !rdTwo |=> rdData == 32'h00000000)
		else $error("read data not zero");
	reset_clear_a: assert property (disable iff (1'h0) reset |=>
		one == 20'h00000 && two == 8'h00 && rdData == 32'h00000000) else $error("reset not clear");
	cover property (wrOne ##[1:4] rdOne);
	cover property (wrTwo ##[1:8] rdTwo);
	cover property (rdStrobe && !rdOne && !rdTwo);
endmodule
bind periph_soft_reset_regs periph_soft_reset_regs_chk chk_u (.*);

// ==== verification/periph_soft_reset_regs_tb_top.sv ====
// self-checking bench for the peripheral soft reset registers
module periph_soft_reset_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0, reset = 1'h1, wrStrobe = 1'h0, rdStrobe = 1'h0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wrData = 32'h0, capTwo = 32'h0, capFour = 32'h0;
	wire [31:0] rdData;
	wire [19:0] unitsOne; // reserved positions tied low below
	wire [7:0] unitsTwo;
	int nFail = 0, nCompared = 0;
	always #20 clk = ~clk;
	// reserved positions have no reset output behind them
	assign {unitsOne[15], unitsOne[13], unitsOne[11:6], unitsOne[3]} = 9'h000;
	periph_soft_reset_regs dut_u (.clk(clk), .reset(reset), .addr(addr), .wrData(wrData),
		.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
		.capability_mask_two(capTwo), .capability_mask_four(capFour),
		.gp_tmr_unit0_rst(unitsOne[16]), .gp_tmr_unit1_rst(unitsOne[17]),
		.gp_tmr_unit2_rst(unitsOne[18]), .gp_tmr_unit3_rst(unitsOne[19]),
		.two_wire_unit0_rst(unitsOne[12]), .two_wire_unit1_rst(unitsOne[14]),
		.sync_serial_unit0_rst(unitsOne[4]), .sync_serial_unit1_rst(unitsOne[5]),
		.async_serial_unit0_rst(unitsOne[0]), .async_serial_unit1_rst(unitsOne[1]),
		.async_serial_unit2_rst(unitsOne[2]), .pin_port_a_rst(unitsTwo[0]),
		.pin_port_b_rst(unitsTwo[1]), .pin_port_c_rst(unitsTwo[2]), .pin_port_d_rst(unitsTwo[3]),
		.pin_port_e_rst(unitsTwo[4]), .pin_port_f_rst(unitsTwo[5]), .pin_port_g_rst(unitsTwo[6]),
		.pin_port_h_rst(unitsTwo[7]));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			nFail++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'h1;
		@(posedge clk);
		wrStrobe <= 1'h0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1'h1;
		@(posedge clk);
		rdStrobe <= 1'h0;
		@(negedge clk);
		chk(rdData, exp);
	endtask
	task automatic endSim();
		if (nFail == 0 && nCompared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'h0;
		rd(12'h044, 32'h00000000);
		rd(12'h048, 32'h00000000);
		// masks and reset move only on a rising edge
		@(posedge clk);
		capTwo <= 32'hFFFFFFFF;
		capFour <= 32'hFFFFFFFF;
		wr(12'h044, 32'hFFFFFFFF);
		rd(12'h044, 32'h000F5037);
		chk({12'h000, unitsOne & 20'hF5037}, 32'h000F5037);
		@(posedge clk);
		capTwo <= 32'h00050005;
		wr(12'h044, 32'h00000000);
		chk({12'h000, unitsOne & 20'hF5037}, 32'h000A5032);
		rd(12'h044, 32'h000A5032);
		@(posedge clk);
		capFour <= 32'h0000000F;
		wr(12'h048, 32'hFFFFFFFF);
		rd(12'h048, 32'h0000000F);
		@(posedge clk);
		capFour <= 32'h000000F0;
		wr(12'h048, 32'h00000000);
		rd(12'h048, 32'h0000000F);
		@(posedge clk);
		capFour <= 32'hFFFFFFFF;
		wr(12'h048, 32'h000000A5);
		chk({24'h000000, unitsTwo}, 32'h000000A5);
		wr(12'h04C, 32'hFFFFFFFF);
		rd(12'h04C, 32'h00000000);
		rd(12'h048, 32'h000000A5);
		@(posedge clk);
		reset <= 1'h1;
		repeat (2) @(posedge clk);
		reset <= 1'h0;
		rd(12'h044, 32'h00000000);
		rd(12'h048, 32'h00000000);
		chk({12'h000, unitsOne & 20'hF5037}, 32'h00000000);
		chk({24'h000000, unitsTwo}, 32'h00000000);
		endSim();
	end
endmodule
